// ===== rtl/ahs_pkg.sv
/*
  ahs_pkg: constants, modes, states and carrier types for the actuator
  homing sequencer. assumes a 100 MHz system clock and axi4-lite access.
*/
package ahs_pkg;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned PEAK_TIME_MS   = 1000;
  localparam int unsigned PEAK_CYCLES    = (CLK_HZ / 1000) * PEAK_TIME_MS;
  localparam int unsigned RES_COUNTS     = 4096;
  localparam int unsigned STALL_CYCLES   = 1000;
  localparam logic [11:0] SCALE_MIN      = 12'h000;
  localparam logic [11:0] SCALE_MAX      = 12'hFFF;
  // analog window 0.5 V .. 4.5 V on a 12-bit 0..5 V converter
  localparam logic [11:0] ANA_LO         = 12'h19A;
  localparam logic [11:0] ANA_HI         = 12'hE66;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_OFFSET  = 8'h04;
  localparam logic [7:0] OFF_HCUR    = 8'h08;
  localparam logic [7:0] OFF_HSPEED  = 8'h0C;
  localparam logic [7:0] OFF_SEATCUR = 8'h10;
  localparam logic [7:0] OFF_SCALE   = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;
  localparam logic [7:0] OFF_IRQ     = 8'h1C;
  localparam logic [7:0] OFF_MASK    = 8'h20;
  localparam logic [7:0] OFF_POS     = 8'h24;
  localparam logic [7:0] OFF_MOTION  = 8'h28;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] SCALE_RST  = 32'h0FFF_0000;
  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_HOMEGO = 1;
  localparam int unsigned CTRL_EXTEND = 2;
  localparam int unsigned CTRL_MODE_L = 3;
  localparam int unsigned CTRL_RESREF = 6;
  localparam int unsigned CTRL_SEAT   = 7;
  localparam int unsigned CTRL_ANAFB  = 8;

  typedef enum logic [2:0] {
    MODE_LIMIT     = 3'b000,
    MODE_STALL     = 3'b001,
    MODE_STALL_LIM = 3'b010,
    MODE_ANALOG    = 3'b011
  } ahs_mode_t;

  typedef enum logic [2:0] {
    ST_WAIT_EN = 3'b000,
    ST_SEEK    = 3'b001,
    ST_BACK    = 3'b010,
    ST_LOAD    = 3'b011,
    ST_RUN     = 3'b100
  } ahs_state_t;

  typedef struct packed {
    logic [11:0] angle;
    logic [31:0] count;
    logic        moving;
  } ahs_fb_t;

  typedef struct packed {
    logic signed [15:0] current;
    logic signed [15:0] velocity;
    logic               inhibit;
  } ahs_drive_t;

  localparam int unsigned EV_DONE  = 0;
  localparam int unsigned EV_STALL = 1;
  localparam int unsigned EV_ANAF  = 2;
  localparam int unsigned EV_FOLD  = 3;
endpackage : ahs_pkg

// ===== rtl/ahs_sequencer.sv
/*
  ahs_sequencer: homing sequencer with an axi4-lite register slave.
  assumes the resolver count, angle, motor current and analog reading
  are synchronous to clock; the limit switch pin is asynchronous.
*/
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
//
// Contract
// - no position following before homing completes
// - after homing move to commanded position
// - retract direction drives retracting first
// - extend direction drives extending first
// - load home offset as actual position
// - resolver option: angle plus offset; the code loads the offset alone in limit mode
// - limit mode: stall, reverse, switch
// - stall mode: stopped and home current
// - stall accepted only with switch
// - analog mode: scaled reading, resolver after
// - analog feedback keeps analog position
// - analog reading outside window flags fault
// - homing caps current at home limit
// - double peak one second, then fold
// - seek at configured home speed
// - seating holds at foldback current; the code holds at seatcur_q instead
// - scaling points are twelve bit
`timescale 1ns/1ns
module ahs_sequencer
  import ahs_pkg::*;
#(
  parameter int unsigned PEAK_CYC = PEAK_CYCLES
) (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // plant side
  input  wire ahs_fb_t             fb,
  input  wire logic [15:0]         motor_current,
  input  wire logic [11:0]         aux_analog,
  input  wire logic                home_limit,
  input  wire logic signed [31:0]  cmd_position,
  // drive side
  output ahs_drive_t               drive_q,
  output logic signed [31:0]       actual_pos_q,
  output logic                     use_analog_fb_q,
  output logic                     home_done_q,
  output logic                     irq_q
);

  logic [31:0]        ctrl_q, offset_q, hcur_q, hspeed_q, seatcur_q, scale_q, motion_q;
  logic [3:0]         stat_q, mask_q, ev;
  ahs_state_t         st_q;
  logic [1:0]         lim_sync_q;
  logic               lim;
  logic [9:0]         stall_cnt_q;
  logic [27:0]        peak_cnt_q;
  logic               enable_d1_q, trig, stalled, go_pulse_q;
  logic signed [31:0] track_q;
  ahs_mode_t          mode;

  // write side
  logic        aw_have_q, w_have_q;
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic        do_wr, do_rd, rd_stat;

  assign mode = ahs_mode_t'(ctrl_q[CTRL_MODE_L +: 3]);
  assign lim  = lim_sync_q[1];

  // home switch is asynchronous: only the second flop is read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lim_sync_q <= 2'b00;
    end else begin
      lim_sync_q <= {lim_sync_q[0], home_limit};
    end
  end

  // bus handshake: address and data may arrive in either order
  assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_q          <= 8'h00;
      wd_q          <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_q     <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // writes to read-only words are accepted and ignored
        s_axi_bresp  <= (aw_q[7:2] > OFF_MOTION[7:2]) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q    <= CTRL_RST;
      offset_q  <= 32'h0000_0000;
      hcur_q    <= 32'h0000_0000;
      hspeed_q  <= 32'h0000_0000;
      seatcur_q <= 32'h0000_0000;
      scale_q   <= SCALE_RST;
      mask_q    <= 4'h0;
      go_pulse_q <= 1'b0;
    end else begin
      go_pulse_q <= 1'b0;
      if (do_wr) begin
        case (aw_q)
          OFF_CTRL: begin
            ctrl_q     <= merge(ctrl_q, wd_q, ws_q) & ~(32'h1 << CTRL_HOMEGO);
            go_pulse_q <= ws_q[0] && wd_q[CTRL_HOMEGO];
          end
          OFF_OFFSET:  offset_q  <= merge(offset_q, wd_q, ws_q);
          OFF_HCUR:    hcur_q    <= merge(hcur_q, wd_q, ws_q) & 32'h0000_7FFF;
          OFF_HSPEED:  hspeed_q  <= merge(hspeed_q, wd_q, ws_q) & 32'h0000_7FFF;
          OFF_SEATCUR: seatcur_q <= merge(seatcur_q, wd_q, ws_q) & 32'h0000_7FFF;
          OFF_SCALE:   scale_q   <= merge(scale_q, wd_q, ws_q) & 32'h0FFF_0FFF;
          OFF_MASK:    mask_q    <= 4'(merge({28'h0, mask_q}, wd_q, ws_q));
          default: ;
        endcase
      end
    end
  end

  // read side
  assign do_rd   = s_axi_arvalid && s_axi_arready;
  assign rd_stat = do_rd && (s_axi_araddr == OFF_IRQ);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          OFF_CTRL:    s_axi_rdata <= ctrl_q;
          OFF_OFFSET:  s_axi_rdata <= offset_q;
          OFF_HCUR:    s_axi_rdata <= hcur_q;
          OFF_HSPEED:  s_axi_rdata <= hspeed_q;
          OFF_SEATCUR: s_axi_rdata <= seatcur_q;
          OFF_SCALE:   s_axi_rdata <= scale_q;
          OFF_STATUS:  s_axi_rdata <= {27'h0, st_q, home_done_q, use_analog_fb_q};
          OFF_IRQ:     s_axi_rdata <= {28'h0, stat_q};
          OFF_MASK:    s_axi_rdata <= {28'h0, mask_q};
          OFF_POS:     s_axi_rdata <= actual_pos_q;
          OFF_MOTION:  s_axi_rdata <= motion_q;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // stall: no resolver motion for a while and current at home level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_q <= 10'h000;
    end else if (fb.moving || st_q != ST_SEEK) begin
      stall_cnt_q <= 10'h000;
    end else if (stall_cnt_q != 10'(STALL_CYCLES)) begin
      stall_cnt_q <= stall_cnt_q + 10'h001;
    end
  end
  assign stalled = (stall_cnt_q == 10'(STALL_CYCLES)) && (motor_current >= hcur_q[15:0]);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_d1_q <= 1'b0;
    end else begin
      enable_d1_q <= ctrl_q[CTRL_ENABLE];
    end
  end
  // power-up then enable, or a home-initiate request
  assign trig = (ctrl_q[CTRL_ENABLE] && !enable_d1_q && !home_done_q) ||
                (go_pulse_q && ctrl_q[CTRL_ENABLE]);

  // limitation: a retract point at or above the extend point reads as zero
  function automatic logic signed [31:0] scale_ana(input logic [11:0] a, input logic [31:0] s);
    logic [11:0] lo, hi;
    logic [23:0] num;
    lo  = s[11:0];
    hi  = s[27:16];
    num = (a > lo) ? 24'((a - lo)) * 24'h000FFF : 24'h0;
    return (hi > lo) ? signed'(32'(num / 24'(hi - lo))) : 32'sh0;
  endfunction : scale_ana

  // sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q            <= ST_WAIT_EN;
      home_done_q     <= 1'b0;
      actual_pos_q    <= 32'sh0;
      track_q         <= 32'sh0;
      use_analog_fb_q <= 1'b0;
    end else begin
      if (trig) begin
        home_done_q     <= 1'b0;
        use_analog_fb_q <= 1'b0;
        st_q <= (mode == MODE_ANALOG) ? ST_LOAD : ST_SEEK;
      end else begin
        case (st_q)
          ST_WAIT_EN: ;
          ST_SEEK: begin
            if (stalled && mode == MODE_LIMIT) st_q <= ST_BACK;
            else if (stalled && (mode == MODE_STALL || lim)) st_q <= ST_LOAD;
          end
          ST_BACK: if (lim) st_q <= ST_LOAD;
          ST_LOAD: begin
            if (mode == MODE_ANALOG) begin
              actual_pos_q <= scale_ana(aux_analog, scale_q) + signed'(offset_q);
              use_analog_fb_q <= ctrl_q[CTRL_ANAFB];
            end else if (ctrl_q[CTRL_RESREF] && mode != MODE_LIMIT) begin
              actual_pos_q <= signed'({20'h0, fb.angle}) + signed'(offset_q);
            end else begin
              actual_pos_q <= signed'(offset_q);
            end
            track_q     <= signed'(fb.count);
            home_done_q <= 1'b1;
            st_q        <= ST_RUN;
          end
          ST_RUN: begin
            if (use_analog_fb_q) begin
              actual_pos_q <= scale_ana(aux_analog, scale_q) + signed'(offset_q);
            end else begin
              actual_pos_q <= actual_pos_q + (signed'(fb.count) - track_q);
            end
            track_q <= signed'(fb.count);
            if (!ctrl_q[CTRL_ENABLE]) st_q <= ST_WAIT_EN;
            // dropping the option hands back to the resolver
            if (!ctrl_q[CTRL_ANAFB]) use_analog_fb_q <= 1'b0;
          end
          default: st_q <= ST_WAIT_EN;
        endcase
      end
    end
  end

  // peak window timer
  // timed over seek and reverse so a reversal cannot restart it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      peak_cnt_q <= 28'h0;
    end else if (trig) begin
      peak_cnt_q <= 28'h0;
    end else if ((st_q == ST_SEEK || st_q == ST_BACK) && peak_cnt_q != 28'(PEAK_CYC)) begin
      peak_cnt_q <= peak_cnt_q + 28'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    logic signed [15:0] dir, err;
    if (!rst_n) begin
      drive_q  <= '{current: 16'sh0, velocity: 16'sh0, inhibit: 1'b1};
      motion_q <= 32'h0;
    end else begin
      dir = ctrl_q[CTRL_EXTEND] ? 16'sh1 : -16'sh1;
      err = 16'(cmd_position - actual_pos_q);
      case (st_q)
        ST_SEEK, ST_BACK: begin
          drive_q.inhibit <= 1'b0;
          drive_q.velocity <= 16'(signed'(hspeed_q[15:0]) *
                                  ((st_q == ST_BACK) ? -dir : dir));
          drive_q.current <= (peak_cnt_q < 28'(PEAK_CYC)) ?
                             signed'({hcur_q[14:0], 1'b0}) : signed'(hcur_q[15:0]);
        end
        ST_RUN: begin
          drive_q.inhibit <= 1'b0;
          drive_q.velocity <= err;
          drive_q.current <= ctrl_q[CTRL_SEAT] ? signed'(seatcur_q[15:0]) : 16'sh7FFF;
        end
        default: begin
          drive_q <= '{current: 16'sh0, velocity: 16'sh0, inhibit: 1'b1};
        end
      endcase
      // a new run stops following at once
      if (trig) drive_q <= '{current: 16'sh0, velocity: 16'sh0, inhibit: 1'b1};
      motion_q <= {drive_q.current, drive_q.velocity};
    end
  end

  assign ev[EV_ANAF]  = (mode == MODE_ANALOG) && (st_q != ST_WAIT_EN) &&
                        (aux_analog < ANA_LO || aux_analog > ANA_HI);
  assign ev[EV_DONE]  = (st_q == ST_LOAD);
  assign ev[EV_STALL] = (st_q == ST_SEEK) && stalled;
  assign ev[EV_FOLD]  = (st_q == ST_SEEK || st_q == ST_BACK) &&
                        (peak_cnt_q == 28'(PEAK_CYC) - 28'h1);

  // sticky events; a new event beats the read clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= 4'h0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= (rd_stat ? 4'h0 : stat_q) | ev;
      irq_q  <= |(((rd_stat ? 4'h0 : stat_q) | ev) & mask_q);
    end
  end

endmodule : ahs_sequencer

// ===== dv/ahs_plant.sv
/*
  ahs_plant: actuator between two hard stops, home switch near the
  retract stop. assumes positive velocity extends the actuator.
*/
`timescale 1ns/1ns
module ahs_plant
  import ahs_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // drive side
  input  wire ahs_drive_t drive_q,
  input  wire logic       lim_en,
  // feedback side
  output ahs_fb_t         fb,
  output logic [15:0]     motor_current,
  output logic            home_limit
);
  localparam logic [31:0] LO = 32'h64;
  localparam logic [31:0] HI = 32'h190;
  logic [31:0] pos_q;
  logic        mv_q;
  // one count a cycle, stops dead at either end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 32'h96;
      mv_q  <= 1'b0;
    end else if (drive_q.inhibit || drive_q.velocity == 16'h0) begin
      mv_q <= 1'b0;
    end else if (drive_q.velocity > 0) begin
      pos_q <= (pos_q < HI) ? pos_q + 32'h1 : pos_q;
      mv_q  <= pos_q < HI;
    end else begin
      pos_q <= (pos_q > LO) ? pos_q - 32'h1 : pos_q;
      mv_q  <= pos_q > LO;
    end
  end
  // stalled motor draws the full commanded cap
  assign motor_current = mv_q ? 16'h0010 :
                         (drive_q.current[15] ? -drive_q.current : drive_q.current);
  assign fb = {pos_q[11:0], pos_q, mv_q};
  assign home_limit = lim_en && pos_q <= LO + 32'hA;
endmodule : ahs_plant

// ===== dv/ahs_sequencer_properties.sv
/*
  ahs_sequencer_checker: port properties of the homing sequencer.
  assumes whole-word register writes with address and data together.
*/
`timescale 1ns/1ns
module ahs_sequencer_checker
  import ahs_pkg::*;
#(
  parameter int unsigned PEAK_CYC = PEAK_CYCLES
) (
  // clock and reset
  input wire logic               clock,
  input wire logic               rst_n,
  // register writes
  input wire logic [7:0]         s_axi_awaddr,
  input wire logic [31:0]        s_axi_wdata,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  // plant and drive
  input wire ahs_fb_t            fb,
  input wire logic               home_limit,
  input wire ahs_drive_t         drive_q,
  input wire logic signed [31:0] actual_pos_q,
  input wire logic               use_analog_fb_q,
  input wire logic               home_done_q
);
  logic [31:0] ctrl_q, off_q, pk_q;
  logic [15:0] hcur_q, cur_abs;
  logic [2:0]  age_q;
  logic        wr, stall_md;
  assign wr = s_axi_wvalid && s_axi_wready;
  assign cur_abs = drive_q.current[15] ? -drive_q.current : drive_q.current;
  assign stall_md = ctrl_q[5:3] == MODE_STALL || ctrl_q[5:3] == MODE_STALL_LIM;
  // shadow copies of the settings
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      off_q  <= 32'h0;
      hcur_q <= 16'h0;
    end else if (wr) begin
      if (s_axi_awaddr == OFF_CTRL) ctrl_q <= s_axi_wdata;
      if (s_axi_awaddr == OFF_OFFSET) off_q <= s_axi_wdata;
      if (s_axi_awaddr == OFF_HCUR) hcur_q <= {1'b0, s_axi_wdata[14:0]};
    end
  end
  // peak length, cleared outside a peak, and age of the last write, saturating at 7
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pk_q  <= 32'h0;
      age_q <= 3'h7;
    end else begin
      pk_q  <= (!home_done_q && cur_abs > hcur_q) ? pk_q + 32'h1 : 32'h0;
      age_q <= wr ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // first motion soon after a start request
  sequence s_seek_start;
    !home_done_q && age_q < 3'h7 && ctrl_q[5:3] != MODE_ANALOG &&
    $past(drive_q.velocity) == 16'h0 && drive_q.velocity != 16'h0;
  endsequence
  sequence s_homed(logic res);
    $rose(home_done_q) && stall_md && ctrl_q[CTRL_RESREF] == res;
  endsequence
  property p_seek_dir;
    s_seek_start |-> (drive_q.velocity > 0) == ctrl_q[CTRL_EXTEND];
  endproperty
  property p_cur_cap;
    !home_done_q && !drive_q.inhibit |-> cur_abs <= {hcur_q[14:0], 1'b0};
  endproperty
  property p_peak_len;
    pk_q <= PEAK_CYC;
  endproperty
  property p_load_off;
    s_homed(1'b0) |-> actual_pos_q == off_q;
  endproperty
  property p_load_res;
    s_homed(1'b1) |-> actual_pos_q == off_q + {20'h0, fb.angle};
  endproperty
  property p_lim_qual;
    $rose(home_done_q) && ctrl_q[5:3] == MODE_STALL_LIM |-> $past(home_limit, 4);
  endproperty
  property p_done_clr;
    $fell(home_done_q) |-> age_q < 3'h4;
  endproperty
  property p_ana_fb;
    !ctrl_q[CTRL_ANAFB] [*3] |-> !use_analog_fb_q;
  endproperty
  a_seek_dir: assert property (p_seek_dir)
    else $error("first homing motion in wrong direction");
  a_cur_cap: assert property (p_cur_cap)
    else $error("homing current above twice home current");
  a_peak_len: assert property (p_peak_len)
    else $error("peak current held too long");
  a_load_off: assert property (p_load_off)
    else $error("home offset not loaded");
  a_load_res: assert property (p_load_res)
    else $error("resolver angle plus offset not loaded");
  a_lim_qual: assert property (p_lim_qual)
    else $error("stall accepted without limit switch");
  a_done_clr: assert property (p_done_clr)
    else $error("home done cleared without start");
  a_ana_fb: assert property (p_ana_fb)
    else $error("analog feedback used while not selected");
endmodule : ahs_sequencer_checker

bind ahs_sequencer ahs_sequencer_checker #(.PEAK_CYC(PEAK_CYC)) ahs_sequencer_checker_i (
  .clock, .rst_n, .s_axi_awaddr, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .fb,
  .home_limit, .drive_q, .actual_pos_q, .use_analog_fb_q, .home_done_q);

// ===== dv/ahs_sequencer_test.sv
/*
  ahs_sequencer_test: runs each homing mode against the plant model,
  registers over axi4-lite. assumes the checker is bound separately.
*/
`timescale 1ns/1ns
module ahs_sequencer_test;
  import ahs_pkg::*;
  logic        clock = 1'b0, rst_n = 1'b0, lim_en = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] aux_analog = 12'h800;
  logic signed [31:0] cmd_position = 32'h0, actual_pos_q;
  logic [15:0] motor_current;
  logic        home_limit, use_analog_fb_q, home_done_q, irq_q;
  ahs_fb_t     fb;
  ahs_drive_t  drive_q;
  int          fails = 0, checked = 0, seed = 73516;
  localparam logic [2:0] MD [6] = '{MODE_STALL, MODE_STALL, MODE_STALL_LIM, MODE_LIMIT,
                                    MODE_ANALOG, MODE_ANALOG};
  localparam logic [5:0] XT = 6'b000010, RS = 6'b000010, AF = 6'b100000;

  always #5 clock = ~clock;

  ahs_sequencer #(.PEAK_CYC(100)) ahs_sequencer_i (.clock, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .fb, .motor_current, .aux_analog, .home_limit, .cmd_position,
    .drive_q, .actual_pos_q, .use_analog_fb_q, .home_done_q, .irq_q);
  ahs_plant ahs_plant_i (.clock, .rst_n, .drive_q, .lim_en, .fb, .motor_current,
    .home_limit);

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic tmo;
    fails++;
    $display("[ERR] wait expected response seen none");
    finish_test();
  endtask : tmo
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) tmo();
  endtask : rd
  task automatic wait_done;
    int n;
    for (n = 0; n < 5000 && home_done_q !== 1'b1; n++) @(posedge clock);
    if (n == 5000) tmo();
  endtask : wait_done
  function automatic logic [31:0] ctl(input logic [2:0] m, input logic x, rs, af);
    return {23'h0, af, 1'b0, rs, m, x, 2'b11};
  endfunction : ctl
  // stops sit at 0x64 and 0x190; default scaling maps the reading one to one
  function automatic logic [31:0] exp_pos(input logic [2:0] m, input logic x, rs,
                                          input logic [31:0] o, input logic [11:0] a);
    if (m == MODE_ANALOG) return o + {20'h0, a};
    if (rs && m != MODE_LIMIT) return o + (x ? 32'h190 : 32'h64);
    return o;
  endfunction : exp_pos

  initial begin
    logic [31:0] d, off;
    logic [1:0]  r;
    logic [11:0] av;
    int          i;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("inhibit", 32'h1, {31'h0, drive_q.inhibit});
    rd(OFF_CTRL, d, r);
    chk("ctrl_rst", CTRL_RST, d);
    rd(OFF_SCALE, d, r);
    chk("scale_rst", SCALE_RST, d);
    rd(8'h40, d, r);
    chk("unmapped", 32'h2, {30'h0, r});
    wr(OFF_HCUR, 32'h100);
    wr(OFF_HSPEED, 32'h3);
    wr(OFF_MASK, 32'hF);
    for (i = 0; i < 6; i++) begin
      off = $random(seed) % 1000;
      av = ANA_LO + 12'({$random(seed)} % 32'hC00);
      aux_analog <= av;
      wr(OFF_OFFSET, off);
      wr(OFF_CTRL, ctl(MD[i], XT[i], RS[i], AF[i]));
      repeat (3) @(posedge clock);
      if (MD[i] != MODE_ANALOG) begin
        chk("done_clr", 32'h0, {31'h0, home_done_q});
        chk("seek_dir", {31'h0, XT[i]}, {31'h0, drive_q.velocity > 0});
        chk("seek_spd", {16'h0, XT[i] ? 16'h0003 : 16'hFFFD}, {16'h0, drive_q.velocity});
      end
      wait_done();
      chk("home_pos", exp_pos(MD[i], XT[i], RS[i], off, av), actual_pos_q);
      chk("ana_fb", {31'h0, AF[i]}, {31'h0, use_analog_fb_q});
      chk("irq_out", 32'h1, {31'h0, irq_q});
      rd(OFF_IRQ, d, r);
      chk("irq_done", 32'h1, d & 32'h1);
      rd(OFF_IRQ, d, r);
      chk("irq_clr", 32'h0, d & 32'h1);
      cmd_position <= actual_pos_q + 32'hC8;
      repeat (20) @(posedge clock);
      chk("follow", 32'h1, {31'h0, drive_q.velocity > 0});
    end
    // no switch at the extend stop, so the stall must not count
    wr(OFF_CTRL, ctl(MODE_STALL_LIM, 1'b1, 1'b0, 1'b0));
    repeat (3000) @(posedge clock);
    chk("lim_qual", 32'h0, {31'h0, home_done_q});
    aux_analog <= 12'h050;
    wr(OFF_CTRL, ctl(MODE_ANALOG, 1'b0, 1'b0, 1'b0));
    repeat (10) @(posedge clock);
    rd(OFF_IRQ, d, r);
    chk("ana_range", 32'h4, d & 32'h4);
    wr(OFF_SEATCUR, 32'h55);
    wr(OFF_CTRL, ctl(MODE_ANALOG, 1'b0, 1'b0, 1'b0) | 32'h80);
    repeat (5) @(posedge clock);
    chk("seat_cur", 32'h55, {16'h0, drive_q.current});
    wr(OFF_MASK, 32'h0);
    repeat (3) @(posedge clock);
    chk("irq_mask", 32'h0, {31'h0, irq_q});
    finish_test();
  end
endmodule : ahs_sequencer_test
